// file: rtl/dit_defines.vh
`ifndef DIT_DEFINES_VH
`define DIT_DEFINES_VH

// register byte offsets
`define DIT_OFF_CTRL 12'h000
`define DIT_OFF_STATUS 12'h004
`define DIT_OFF_COUNT 12'h008
`define DIT_OFF_SEL_BASE 12'h010
`define DIT_SEL_STRIDE 12'h004

// control register fields
`define DIT_CTRL_GAIN_LSB 0
`define DIT_CTRL_GAIN_MSB 1
`define DIT_CTRL_STOP_LSB 2
`define DIT_CTRL_STOP_MSB 3
`define DIT_CTRL_UPDN_BIT 4
`define DIT_CTRL_RESET 32'h00000000

// terminal function codes
`define DIT_FN_WIDTH 6
`define DIT_FN_NONE 6'h00
`define DIT_FN_PLC_PAUSE 6'h12
`define DIT_FN_PLC_STOP 6'h13
`define DIT_FN_PID_PAUSE 6'h14
`define DIT_FN_PID_GAIN 6'h15
`define DIT_FN_CNT_TRIG 6'h16
`define DIT_FN_CNT_CLR 6'h17
`define DIT_FN_LEN_CLR 6'h18
`define DIT_FN_RAMP_HOLD 6'h19
`define DIT_FN_DC_BRAKE 6'h1A
`define DIT_FN_UPDN_CLR 6'h1B

// setting values that enable a function
`define DIT_GAIN_BY_TERMINAL 2'h1
`define DIT_STOP_DEC_DC 2'h2

// status register fields
`define DIT_ST_PLC_PAUSE 0
`define DIT_ST_PLC_STOP 1
`define DIT_ST_PID_HOLD 2
`define DIT_ST_GAIN_SECOND 3
`define DIT_ST_LEN_CLR 4
`define DIT_ST_RAMP_HOLD 5
`define DIT_ST_DC_BRAKE 6
`define DIT_ST_UPDN_CLR 7
`define DIT_ST_CNT_CLR 8
`define DIT_ST_CNT_TRIG 9

`endif

// file: rtl/dit_terminal_functions.v
`include "dit_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module dit_terminal_functions #(
    parameter NUM_TERM = 8,
    parameter CNT_WIDTH = 16
) (
    input wire clk, // 250 MHz system clock
    input wire sys_rst, // synchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    input wire [NUM_TERM-1:0] term_in, // raw terminal levels, high = closed
    input wire jog_active, // core is in jog operation
    input wire stop_cmd, // core has a stop command pending
    output reg plc_pause, // suspend program, zero frequency
    output reg plc_step_freeze, // stop advancing program step timer
    output reg plc_start_block, // program not allowed to start
    output reg plc_decel_stop, // decelerate and stop running program
    output reg plc_reset, // return program to initial state
    output reg pid_hold, // hold frequency, no pid regulation
    output reg pid_gain_second, // high selects second pid gain set
    output reg length_clear, // hold actual length at zero
    output reg ramp_hold, // keep current speed, ignore speed changes
    output reg dc_brake_now, // apply dc braking at once
    output reg updown_clear, // clear up/down accumulated frequency
    output reg [CNT_WIDTH-1:0] count_value // built-in counter, for nonvolatile save
);

    // per-terminal function codes side by side, one slice per terminal
    wire [NUM_TERM*`DIT_FN_WIDTH-1:0] sel_flat;
    // synchronisers and control state
    reg [NUM_TERM-1:0] term_meta;
    reg [NUM_TERM-1:0] term_sync;
    reg [31:0] ctrl;
    reg trig_prev;

    wire [1:0] pid_gain_switch_condition;
    wire [1:0] stop_mode_select;
    wire terminal_increment_decrement_frequency;

    wire [NUM_TERM-1:0] hit_plc_pause;
    wire [NUM_TERM-1:0] hit_plc_stop;
    wire [NUM_TERM-1:0] hit_pid_pause;
    wire [NUM_TERM-1:0] hit_pid_gain;
    wire [NUM_TERM-1:0] hit_cnt_trig;
    wire [NUM_TERM-1:0] hit_cnt_clr;
    wire [NUM_TERM-1:0] hit_len_clr;
    wire [NUM_TERM-1:0] hit_ramp;
    wire [NUM_TERM-1:0] hit_brake;
    wire [NUM_TERM-1:0] hit_updn;

    wire fn_plc_pause;
    wire fn_plc_stop;
    wire fn_pid_pause;
    wire fn_pid_gain;
    wire fn_cnt_trig;
    wire fn_cnt_clr;
    wire fn_len_clr;
    wire fn_ramp;
    wire fn_brake;
    wire fn_updn;

    wire apb_access;
    wire apb_write;
    // address decode
    wire at_ctrl;
    wire at_status;
    wire at_count;
    wire [31:0] status_word;
    wire sel_hit;
    wire [11:0] sel_rel;
    wire [9:0] sel_idx_full;
    wire addr_ok;

    reg [31:0] next_prdata;
    reg next_pslverr;
    reg [CNT_WIDTH-1:0] next_count;

    // next values of the function outputs, one per output flop
    reg next_plc_pause;
    reg next_plc_step_freeze;
    reg next_plc_start_block;
    reg next_plc_decel_stop;
    reg next_plc_reset;
    reg next_pid_hold;
    reg next_pid_gain_second;
    reg next_length_clear;
    reg next_ramp_hold;
    reg next_dc_brake_now;
    reg next_updown_clear;

    // setting qualifiers and counter events
    wire gain_by_terminal;
    wire brake_mode_ok;
    wire updn_source;
    wire cnt_rise;
    wire cnt_load;

    integer k;

    assign pid_gain_switch_condition = ctrl[`DIT_CTRL_GAIN_MSB:`DIT_CTRL_GAIN_LSB];
    assign stop_mode_select = ctrl[`DIT_CTRL_STOP_MSB:`DIT_CTRL_STOP_LSB];
    assign terminal_increment_decrement_frequency = ctrl[`DIT_CTRL_UPDN_BIT];

    // other condition and stop-mode values leave the terminal without effect
    assign gain_by_terminal = (pid_gain_switch_condition == `DIT_GAIN_BY_TERMINAL);
    assign brake_mode_ok = (stop_mode_select == `DIT_STOP_DEC_DC);
    assign updn_source = terminal_increment_decrement_frequency;

    // two-flop synchronisers, contacts are asynchronous to clk
    // bounce is not filtered: a bouncing trigger contact counts every bounce,
    // so the contact side must be clean or debounced
    always @(posedge clk) begin
        if (sys_rst) begin
            term_meta <= {NUM_TERM{1'b0}};
            term_sync <= {NUM_TERM{1'b0}};
        end else begin
            term_meta <= term_in;
            term_sync <= term_meta;
        end
    end

    // decode: a function is active if any terminal assigned to it is closed
    // several terminals may carry the same code; any closed one makes it active
    genvar g;
    generate
        for (g = 0; g < NUM_TERM; g = g + 1) begin : g_term
            wire [`DIT_FN_WIDTH-1:0] code;
            assign code = sel_flat[g*`DIT_FN_WIDTH +: `DIT_FN_WIDTH];
            assign hit_plc_pause[g] = term_sync[g] && (code == `DIT_FN_PLC_PAUSE);
            assign hit_plc_stop[g] = term_sync[g] && (code == `DIT_FN_PLC_STOP);
            assign hit_pid_pause[g] = term_sync[g] && (code == `DIT_FN_PID_PAUSE);
            assign hit_pid_gain[g] = term_sync[g] && (code == `DIT_FN_PID_GAIN);
            assign hit_cnt_trig[g] = term_sync[g] && (code == `DIT_FN_CNT_TRIG);
            assign hit_cnt_clr[g] = term_sync[g] && (code == `DIT_FN_CNT_CLR);
            assign hit_len_clr[g] = term_sync[g] && (code == `DIT_FN_LEN_CLR);
            assign hit_ramp[g] = term_sync[g] && (code == `DIT_FN_RAMP_HOLD);
            assign hit_brake[g] = term_sync[g] && (code == `DIT_FN_DC_BRAKE);
            assign hit_updn[g] = term_sync[g] && (code == `DIT_FN_UPDN_CLR);
        end
    endgenerate

    // function levels, or of every matching terminal
    assign fn_plc_pause = |hit_plc_pause;
    assign fn_plc_stop = |hit_plc_stop;
    assign fn_pid_pause = |hit_pid_pause;
    assign fn_pid_gain = |hit_pid_gain;
    assign fn_cnt_trig = |hit_cnt_trig;
    assign fn_cnt_clr = |hit_cnt_clr;
    assign fn_len_clr = |hit_len_clr;
    assign fn_ramp = |hit_ramp;
    assign fn_brake = |hit_brake;
    assign fn_updn = |hit_updn;

    // apb decode; one wait state so every bus output comes from a flop
    // pready itself masks the answer cycle, so a held access is not taken twice
    assign apb_access = psel && penable && !pready;
    assign apb_write = psel && penable && pready && pwrite && !pslverr;
    assign at_ctrl = (paddr == `DIT_OFF_CTRL);
    assign at_status = (paddr == `DIT_OFF_STATUS);
    assign at_count = (paddr == `DIT_OFF_COUNT);
    assign sel_rel = paddr - `DIT_OFF_SEL_BASE;
    assign sel_idx_full = sel_rel[11:2];
    assign sel_hit = (paddr >= `DIT_OFF_SEL_BASE) && (sel_idx_full < NUM_TERM)
        && (paddr[1:0] == 2'h0);
    assign addr_ok = at_ctrl || at_status || at_count || sel_hit;

    // status word, read only; upper bits read zero
    // the counter functions show their raw level, not a derived output
    assign status_word[31:10] = 22'h0;
    assign status_word[`DIT_ST_PLC_PAUSE] = plc_pause;
    assign status_word[`DIT_ST_PLC_STOP] = plc_reset;
    assign status_word[`DIT_ST_PID_HOLD] = pid_hold;
    assign status_word[`DIT_ST_GAIN_SECOND] = pid_gain_second;
    assign status_word[`DIT_ST_LEN_CLR] = length_clear;
    assign status_word[`DIT_ST_RAMP_HOLD] = ramp_hold;
    assign status_word[`DIT_ST_DC_BRAKE] = dc_brake_now;
    assign status_word[`DIT_ST_UPDN_CLR] = updown_clear;
    assign status_word[`DIT_ST_CNT_CLR] = fn_cnt_clr;
    assign status_word[`DIT_ST_CNT_TRIG] = fn_cnt_trig;

    // read mux, registered into prdata at the wait-state edge
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = !addr_ok;
        if (at_ctrl) begin
            next_prdata = {27'h0, ctrl[4:0]};
        end else if (at_status) begin
            next_prdata = status_word;
        end else if (at_count) begin
            next_prdata[CNT_WIDTH-1:0] = count_value;
        end else if (sel_hit) begin
            for (k = 0; k < NUM_TERM; k = k + 1) begin
                if (sel_idx_full == k[9:0]) begin
                    next_prdata[`DIT_FN_WIDTH-1:0] = sel_flat[k*`DIT_FN_WIDTH +: `DIT_FN_WIDTH];
                end
            end
        end
    end

    // bus handshake: pready rises in the second access cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && next_pslverr;
            prdata <= (apb_access && !pwrite) ? next_prdata : 32'h00000000;
        end
    end

    // control register, written only at the completing edge
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `DIT_CTRL_RESET;
        end else if (apb_write && (paddr == `DIT_OFF_CTRL)) begin
            // upper bits are not kept and read back as zero
            ctrl <= {27'h0, pwdata[4:0]};
        end
    end

    // function selection per terminal; each slice has its own register, one driver
    // reset leaves every terminal without function
    generate
        for (g = 0; g < NUM_TERM; g = g + 1) begin : g_sel
            reg [`DIT_FN_WIDTH-1:0] code_q;
            always @(posedge clk) begin
                if (sys_rst) begin
                    code_q <= `DIT_FN_NONE;
                end else if (apb_write && sel_hit && (sel_idx_full == g)) begin
                    code_q <= pwdata[`DIT_FN_WIDTH-1:0];
                end
            end
            assign sel_flat[g*`DIT_FN_WIDTH +: `DIT_FN_WIDTH] = code_q;
        end
    endgenerate

    // counter edge detector reads the second sync stage only
    always @(posedge clk) begin
        if (sys_rst) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= fn_cnt_trig;
        end
    end

    // counter events; a load is software putting back the count it saved
    assign cnt_rise = fn_cnt_trig && !trig_prev;
    assign cnt_load = apb_write && at_count;

    // counter next value: clear beats restore beats count
    // clear is a level, so loads and pulses while it is held are lost
    always @* begin
        next_count = count_value;
        if (fn_cnt_clr) begin
            next_count = {CNT_WIDTH{1'b0}};
        end else if (cnt_load) begin
            next_count = pwdata[CNT_WIDTH-1:0];
        end else if (cnt_rise) begin
            next_count = count_value + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // synchronised edges at 250 MHz follow pulse rates far beyond 200 Hz;
    // power-fail keep is by software saving count_value and writing it back
    always @(posedge clk) begin
        if (sys_rst) begin
            count_value <= {CNT_WIDTH{1'b0}};
        end else begin
            count_value <= next_count;
        end
    end

    // function outputs, next values; all levels, so release needs no command
    // each output lands three edges after its pin moves: two sync flops, one here
    always @* begin
        next_plc_pause = fn_plc_pause;
        next_plc_step_freeze = fn_plc_pause;
        next_plc_start_block = fn_plc_stop;
        next_plc_decel_stop = fn_plc_stop;
        next_plc_reset = fn_plc_stop;
        next_pid_hold = fn_pid_pause;
        // other condition values keep the first gain set
        next_pid_gain_second = gain_by_terminal && fn_pid_gain;
        next_length_clear = fn_len_clr;
        // stop must still get through, and jog is never frozen
        next_ramp_hold = fn_ramp && !stop_cmd && !jog_active;
        next_dc_brake_now = fn_brake && brake_mode_ok;
        next_updown_clear = fn_updn && updn_source;
    end

    // output flops, so every function output comes straight from a register
    always @(posedge clk) begin
        if (sys_rst) begin
            plc_pause <= 1'b0;
            plc_step_freeze <= 1'b0;
            plc_start_block <= 1'b0;
            plc_decel_stop <= 1'b0;
            plc_reset <= 1'b0;
            pid_hold <= 1'b0;
            pid_gain_second <= 1'b0;
            length_clear <= 1'b0;
            ramp_hold <= 1'b0;
            dc_brake_now <= 1'b0;
            updown_clear <= 1'b0;
        end else begin
            plc_pause <= next_plc_pause;
            plc_step_freeze <= next_plc_step_freeze;
            plc_start_block <= next_plc_start_block;
            plc_decel_stop <= next_plc_decel_stop;
            plc_reset <= next_plc_reset;
            pid_hold <= next_pid_hold;
            pid_gain_second <= next_pid_gain_second;
            length_clear <= next_length_clear;
            ramp_hold <= next_ramp_hold;
            dc_brake_now <= next_dc_brake_now;
            updown_clear <= next_updown_clear;
        end
    end

endmodule // dit_terminal_functions

`default_nettype wire

// file: sim/dit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dit_monitor #(
    parameter NUM_TERM = 8,
    parameter CNT_WIDTH = 16
) (
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic jog_active, // jog running
    input wire logic stop_cmd, // stop pending
    input wire logic plc_pause, // program pause
    input wire logic plc_step_freeze, // step timer frozen
    input wire logic plc_start_block, // start blocked
    input wire logic plc_decel_stop, // program stopping
    input wire logic plc_reset, // program reset
    input wire logic ramp_hold, // speed frozen
    input wire logic [CNT_WIDTH-1:0] count_value // counter
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // access phase waiting, then a one-cycle answer
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_ready_pulse: assert property (s_access |=> s_answer)
        else $error("pready not a single pulse after access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata nonzero outside read answer");
    a_pause_pair: assert property (plc_pause == plc_step_freeze)
        else $error("pause and step freeze differ");
    a_stop_group: assert property (plc_start_block == plc_reset
        && plc_decel_stop == plc_reset)
        else $error("stop-and-reset outputs differ");
    a_ramp_gate: assert property (ramp_hold |->
        !$past(jog_active) && !$past(stop_cmd))
        else $error("ramp hold during jog or stop");
    a_ramp_stop: assert property (stop_cmd |=> !ramp_hold)
        else $error("ramp hold after stop command");
    // counter moves only by one step, a clear or a software load
    a_count_step: assert property ($changed(count_value) |->
        count_value == $past(count_value) + 1'b1
        || count_value == 0 || $past(pready && pwrite && paddr == 12'h008))
        else $error("counter jumped");
endmodule // dit_monitor
bind dit_terminal_functions dit_monitor #(.NUM_TERM(NUM_TERM), .CNT_WIDTH(CNT_WIDTH))
    dit_monitor_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .jog_active, .stop_cmd, .plc_pause, .plc_step_freeze, .plc_start_block,
    .plc_decel_stop, .plc_reset, .ramp_hold, .count_value);
`default_nettype wire

// file: sim/dit_contacts.sv
`timescale 1ns/100ps
`default_nettype none
module dit_contacts #(
    parameter NUM_TERM = 8
) (
    input wire logic clk, // bench clock
    input wire logic [NUM_TERM-1:0] close_req, // wanted contact state
    output logic [NUM_TERM-1:0] term_in // contact levels, high = closed
);
    // contacts settle a cycle after the request; bounce is not modelled
    initial term_in = '0;
    always @(posedge clk) begin
        term_in <= close_req;
    end
endmodule // dit_contacts
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, sys_rst, psel, penable, pwrite, jog_active, stop_cmd, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] close_req, term_in;
    logic plc_pause, plc_step_freeze, plc_start_block, plc_decel_stop, plc_reset, pid_hold;
    logic pid_gain_second, length_clear, ramp_hold, dc_brake_now, updown_clear;
    logic [15:0] count_value;
    int n_errors = 0;
    int checked = 0;
    logic [5:0] codes [8] = '{6'h12, 6'h13, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1A, 6'h1B};
    logic [10:0] exps [8] = '{11'h600, 11'h1C0, 11'h020, 11'h010,
        11'h008, 11'h004, 11'h002, 11'h001};
    wire [10:0] outs = {plc_pause, plc_step_freeze, plc_start_block, plc_decel_stop, plc_reset,
        pid_hold, pid_gain_second, length_clear, ramp_hold, dc_brake_now, updown_clear};
    dit_terminal_functions dit_terminal_functions_inst (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
        .jog_active(jog_active), .stop_cmd(stop_cmd), .plc_pause(plc_pause),
        .plc_step_freeze(plc_step_freeze), .plc_start_block(plc_start_block),
        .plc_decel_stop(plc_decel_stop), .plc_reset(plc_reset), .pid_hold(pid_hold),
        .pid_gain_second(pid_gain_second), .length_clear(length_clear),
        .ramp_hold(ramp_hold), .dc_brake_now(dc_brake_now), .updown_clear(updown_clear),
        .count_value(count_value));
    dit_contacts dit_contacts_inst (.clk(clk), .close_req(close_req), .term_in(term_in));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready; an idle cycle after keeps drives apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // terminal 0 gets a code; outputs while closed, and all released after opening
    task automatic lvl(input logic [5:0] code, input logic [10:0] exp);
        apb(1'b1, 12'h010, {26'h0, code});
        close_req <= 8'h01;
        repeat (6) @(posedge clk);
        chk("outputs closed", {21'h0, exp}, {21'h0, outs});
        @(posedge clk);
        close_req <= 8'h00;
        repeat (6) @(posedge clk);
        chk("outputs opened", 32'h0, {21'h0, outs});
        @(posedge clk);
    endtask
    task automatic pulse(input logic [7:0] keep);
        close_req <= keep | 8'h02;
        repeat (4) @(posedge clk);
        close_req <= keep;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        apb(1'b0, 12'h004, 32'h0);
        chk("status read only", 32'h0, rd);
        $display("t_regs done");
    endtask
    task automatic t_levels;
        apb(1'b1, 12'h000, 32'h00000019);
        for (int i = 0; i < 8; i++) begin
            lvl(codes[i], exps[i]);
        end
        $display("t_levels done");
    endtask
    task automatic t_gating;
        apb(1'b1, 12'h000, 32'h00000004);
        lvl(6'h15, 11'h000);
        lvl(6'h1A, 11'h000);
        lvl(6'h1B, 11'h000);
        jog_active <= 1'b1;
        lvl(6'h19, 11'h000);
        jog_active <= 1'b0;
        stop_cmd <= 1'b1;
        lvl(6'h19, 11'h000);
        stop_cmd <= 1'b0;
        $display("t_gating done");
    endtask
    task automatic t_counter;
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h014, 32'h16);
        apb(1'b1, 12'h018, 32'h17);
        apb(1'b0, 12'h014, 32'h0);
        chk("select readback", 32'h16, rd);
        repeat (5) pulse(8'h00);
        chk("count after pulses", 32'h5, {16'h0, count_value});
        apb(1'b1, 12'h008, 32'h1234);
        apb(1'b0, 12'h008, 32'h0);
        chk("restored count", 32'h1234, rd);
        pulse(8'h00);
        chk("count resumes", 32'h1235, {16'h0, count_value});
        @(posedge clk);
        close_req <= 8'h04;
        repeat (6) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        chk("status clear level", 32'h100, rd);
        pulse(8'h04);
        chk("count held clear", 32'h0, {16'h0, count_value});
        @(posedge clk);
        close_req <= 8'h00;
        repeat (4) @(posedge clk);
        pulse(8'h00);
        chk("count after clear", 32'h1, {16'h0, count_value});
        $display("t_counter done");
    endtask
    // main sequence: reset for four cycles, then the scenarios
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, jog_active, stop_cmd} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        close_req = 8'h00;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_levels;
        t_gating;
        t_counter;
        end_of_test;
    end
    // watchdog, well beyond the expected run of about four hundred cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
